/* File: rtl/fmsl_pkg.sv */
// Constants, register map and carrier types of the status LED driver
`default_nettype none
package fmsl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] CAN_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] DN_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] LED_OFS = 12'h00C;

  // Control register fields
  localparam int CTRL_PERS_BIT = 0;
  localparam logic CTRL_PERS_RST = 1'h0;
  localparam logic PERS_CAN = 1'h0;
  localparam logic PERS_DN = 1'h1;

  // Indicator readback fields
  localparam int LED_GREEN_BIT = 0;
  localparam int LED_RED_BIT = 1;
  localparam int LED_IND_POS = 8;
  localparam int LED_TIME_POS = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Node management states, CAN personality
  localparam logic [1:0] NMT_INIT = 2'h0;
  localparam logic [1:0] NMT_STOPPED = 2'h1;
  localparam logic [1:0] NMT_PREOP = 2'h2;
  localparam logic [1:0] NMT_OPER = 2'h3;

  // CAN personality status word, low bits of its register
  localparam int CAN_W = 7;
  typedef struct packed {
    logic no_cfg;
    logic reset_busy;
    logic bus_off;
    logic ctrl_event;
    logic warn;
    logic [1:0] nmt;
  } fmsl_can_t;
  localparam logic [CAN_W-1:0] CAN_RST = 7'h40;

  // DeviceNet personality status word, low bits of its register
  localparam int DN_W = 10;
  typedef struct packed {
    logic selftest;
    logic dup_done;
    logic dup_addr;
    logic bus_off;
    logic no_power;
    logic minor_fault;
    logic conn_timeout;
    logic online;
    logic all_conn;
    logic cfg_bad;
  } fmsl_dn_t;
  localparam logic [DN_W-1:0] DN_RST = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Indications shown on the bicolour LED
  typedef enum logic [3:0] {
    IND_OFF,
    IND_G_ON,
    IND_G_BLINK,
    IND_G_SFLASH,
    IND_R_SFLASH,
    IND_R_DFLASH,
    IND_R_ON,
    IND_G_FLASH,
    IND_R_FLASH,
    IND_SELFTEST
  } fmsl_ind_t;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int T_W = 11;
  localparam int SHORT_MS = 200;
  localparam int LONG_OFF_MS = 1000;
  localparam int FLASH_MS = 500;
  localparam int SELFTEST_MS = 250;
  localparam logic [T_W-1:0] SHORT_T = T_W'(SHORT_MS);
  localparam logic [T_W-1:0] BLINK_PER = T_W'(2 * SHORT_MS);
  localparam logic [T_W-1:0] SFLASH_PER = T_W'(SHORT_MS + LONG_OFF_MS);
  localparam logic [T_W-1:0] DFLASH_ON2 = T_W'(2 * SHORT_MS);
  localparam logic [T_W-1:0] DFLASH_OFF2 = T_W'(3 * SHORT_MS);
  localparam logic [T_W-1:0] DFLASH_PER =
    T_W'(3 * SHORT_MS + LONG_OFF_MS);
  localparam logic [T_W-1:0] FLASH_T = T_W'(FLASH_MS);
  localparam logic [T_W-1:0] FLASH_PER = T_W'(2 * FLASH_MS);
  localparam logic [T_W-1:0] SELF_G_T = T_W'(SELFTEST_MS);
  localparam logic [T_W-1:0] SELF_END = T_W'(2 * SELFTEST_MS);

endpackage
`default_nettype wire

/* File: rtl/fmsl_ms_tick.sv */
// Millisecond tick divider with synchronous restart
`default_nettype none
module fmsl_ms_tick #(
  parameter int CYCLES = fmsl_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic restart,
  // Tick out
  output logic tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q == LAST);
  assign tick = wrap && !restart;
  assign cnt_d = (restart || wrap) ? '0 : cnt_q + CW'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/fmsl_top.sv */
// Fieldbus master status LED driver with APB register access
//
// Function
// - CAN mode, operational state lights green steadily.
// - CAN mode, preoperational state blinks green at 2.5 Hz.
// - CAN mode, stopped state shows green single flash.
// - CAN mode, error counter at warning level shows red single flash.
// - CAN mode, guarding or heartbeat event shows red double flash.
// - CAN mode, bus off lights red steadily.
// - CAN mode, reset in progress or no configuration keeps LED dark.
// - Blinking is 200 ms on, 200 ms off, repeating.
// - Single flash is 200 ms on, then 1000 ms off, repeating.
// - Double flash is on, off, on 200 ms each, then 1000 ms off.
// - DeviceNet mode, online with all connections lights green steadily.
// - DeviceNet mode, no connection or bad configuration flashes green 1 Hz.
// - DeviceNet self-test shows green 250 ms, red 250 ms, then off.
// - DeviceNet mode, recoverable fault flashes red at 1 Hz.
// - DeviceNet mode, duplicate address or bus off lights red steadily.
// - DeviceNet mode, dark until address check done or without power.
// - 1 Hz flashing is 500 ms on, 500 ms off, repeating.
//
// The address map and the APB slave port were decided locally.
`default_nettype none
module fmsl_top
  import fmsl_pkg::*;
#(
  parameter int MS_TICK_CYCLES = fmsl_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fmsl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bicolour LED drive
  output logic led_red,
  output logic led_green
);

  import fmsl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic setup_ph;
  logic write_en;
  logic hit_ctrl;
  logic hit_can;
  logic hit_dn;
  logic hit_led;
  logic hit_any;
  logic [31:0] rd_mux;

  assign setup_ph = psel && !penable;
  assign write_en = psel && penable && pwrite && hit_any;
  assign hit_ctrl = (paddr == CTRL_OFS);
  assign hit_can = (paddr == CAN_OFS);
  assign hit_dn = (paddr == DN_OFS);
  assign hit_led = (paddr == LED_OFS);
  assign hit_any = hit_ctrl || hit_can || hit_dn || hit_led;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic pers_q;
  logic pers_d;
  fmsl_can_t can_q;
  fmsl_can_t can_d;
  fmsl_dn_t dn_q;
  fmsl_dn_t dn_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  assign pers_d = (write_en && hit_ctrl) ? pwdata[CTRL_PERS_BIT] : pers_q;
  assign can_d = (write_en && hit_can) ? fmsl_can_t'(pwdata[CAN_W-1:0])
                                       : can_q;
  assign dn_d = (write_en && hit_dn) ? fmsl_dn_t'(pwdata[DN_W-1:0]) : dn_q;

  // Read data latched in the setup phase, stable in the access phase
  assign prdata_d = setup_ph ? rd_mux : prdata_q;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pers_q <= CTRL_PERS_RST;
      can_q <= fmsl_can_t'(CAN_RST);
      dn_q <= fmsl_dn_t'(DN_RST);
      prdata_q <= 32'h0000_0000;
    end else begin
      pers_q <= pers_d;
      can_q <= can_d;
      dn_q <= dn_d;
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indication selection

  fmsl_ind_t ind_q;
  fmsl_ind_t ind_d;
  fmsl_ind_t can_ind;
  fmsl_ind_t dn_ind;
  fmsl_ind_t can_green_ind;
  logic dn_critical;
  logic dn_minor;

  // Green indication follows node management state
  assign can_green_ind =
    (can_q.nmt == NMT_OPER) ? IND_G_ON :
    (can_q.nmt == NMT_PREOP) ? IND_G_BLINK :
    (can_q.nmt == NMT_STOPPED) ? IND_G_SFLASH :
    IND_OFF;

  // Severity order, darkest condition first
  assign can_ind =
    (can_q.reset_busy || can_q.no_cfg) ? IND_OFF :
    can_q.bus_off ? IND_R_ON :
    can_q.ctrl_event ? IND_R_DFLASH :
    can_q.warn ? IND_R_SFLASH :
    can_green_ind;

  assign dn_critical = dn_q.dup_addr || dn_q.bus_off;
  assign dn_minor = dn_q.minor_fault || dn_q.conn_timeout;

  assign dn_ind =
    dn_q.selftest ? IND_SELFTEST :
    !dn_q.dup_done ? IND_OFF :
    dn_critical ? IND_R_ON :
    dn_q.no_power ? IND_OFF :
    dn_minor ? IND_R_FLASH :
    (dn_q.online && dn_q.all_conn) ? IND_G_ON :
    (dn_q.online || dn_q.cfg_bad) ? IND_G_FLASH :
    IND_OFF;

  assign ind_d = (pers_q == PERS_DN) ? dn_ind : can_ind;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern timer

  logic restart;
  logic ms_tick;
  logic [T_W-1:0] t_q;
  logic [T_W-1:0] t_d;
  logic [T_W-1:0] period;
  logic t_wrap;
  logic t_hold;

  assign restart = (ind_d != ind_q);

  fmsl_ms_tick #(
    .CYCLES(MS_TICK_CYCLES)
  ) u_ms_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .tick(ms_tick)
  );

  // Repeat period of each flashing indication
  always_comb begin
    case (ind_q)
      IND_G_BLINK: period = BLINK_PER;
      IND_G_SFLASH: period = SFLASH_PER;
      IND_R_SFLASH: period = SFLASH_PER;
      IND_R_DFLASH: period = DFLASH_PER;
      IND_G_FLASH: period = FLASH_PER;
      IND_R_FLASH: period = FLASH_PER;
      IND_SELFTEST: period = SELF_END;
      default: period = BLINK_PER;
    endcase
  end

  // Self-test runs once and then rests dark
  assign t_hold = (ind_q == IND_SELFTEST) && (t_q == SELF_END);
  assign t_wrap = (t_q == period - T_W'(1)) && (ind_q != IND_SELFTEST);
  assign t_d = restart ? '0 :
               !ms_tick || t_hold ? t_q :
               t_wrap ? '0 :
               t_q + T_W'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_q <= IND_OFF;
      t_q <= '0;
    end else begin
      ind_q <= ind_d;
      t_q <= t_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED drive

  logic short_on;
  logic dbl_on;
  logic flash_on;
  logic red_d;
  logic green_d;
  logic red_q;
  logic green_q;

  assign short_on = (t_q < SHORT_T);
  assign dbl_on = short_on || ((t_q >= DFLASH_ON2) && (t_q < DFLASH_OFF2));
  assign flash_on = (t_q < FLASH_T);

  always_comb begin
    red_d = 1'b0;
    green_d = 1'b0;
    case (ind_q)
      IND_G_ON: green_d = 1'b1;
      IND_G_BLINK: green_d = short_on;
      IND_G_SFLASH: green_d = short_on;
      IND_R_SFLASH: red_d = short_on;
      IND_R_DFLASH: red_d = dbl_on;
      IND_R_ON: red_d = 1'b1;
      IND_G_FLASH: green_d = flash_on;
      IND_R_FLASH: red_d = flash_on;
      IND_SELFTEST: begin
        green_d = (t_q < SELF_G_T);
        red_d = (t_q >= SELF_G_T) && (t_q < SELF_END);
      end
      IND_OFF: begin
        red_d = 1'b0;
        green_d = 1'b0;
      end
      default: begin
        red_d = 1'b0;
        green_d = 1'b0;
      end
    endcase
  end

  // Red wins so both elements are never lit together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_q <= 1'b0;
      green_q <= 1'b0;
    end else begin
      red_q <= red_d;
      green_q <= green_d && !red_d;
    end
  end

  assign led_red = red_q;
  assign led_green = green_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  logic [31:0] ctrl_rd;
  logic [31:0] can_rd;
  logic [31:0] dn_rd;
  logic [31:0] led_rd;

  assign ctrl_rd = {31'h0000_0000, pers_q};
  assign can_rd = {{(32 - CAN_W){1'b0}}, can_q};
  assign dn_rd = {{(32 - DN_W){1'b0}}, dn_q};
  assign led_rd = {{(32 - LED_TIME_POS - T_W){1'b0}}, t_q,
                   {(LED_TIME_POS - LED_IND_POS - 4){1'b0}}, ind_q,
                   {(LED_IND_POS - 2){1'b0}}, red_q, green_q};

  assign rd_mux = hit_ctrl ? ctrl_rd :
                  hit_can ? can_rd :
                  hit_dn ? dn_rd :
                  hit_led ? led_rd :
                  32'h0000_0000;

endmodule
`default_nettype wire

/* File: test/fmsl_monitor.sv */
// Port assertions of the status LED driver
`default_nettype none
module fmsl_monitor
  import fmsl_pkg::*;
#(
  parameter int MS_TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fmsl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // LED
  input wire logic led_red,
  input wire logic led_green
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic pers_q;
  fmsl_can_t can_q;
  fmsl_dn_t dn_q;
  fmsl_can_t cw;
  fmsl_dn_t dw;
  assign cw = pwdata[CAN_W-1:0];
  assign dw = pwdata[DN_W-1:0];
  wire wr = psel && penable && pwrite;
  wire can_w = wr && paddr == CAN_OFS && pers_q == PERS_CAN;
  wire dn_w = wr && paddr == DN_OFS && pers_q == PERS_DN;
  // Writes that leave a dark indication
  wire can_go = can_w && can_q.no_cfg && !cw.no_cfg && !cw.reset_busy;
  wire can_err = cw.bus_off || cw.ctrl_event || cw.warn;
  wire dn_go = dn_w && !dn_q.dup_done && !dn_q.selftest && !dw.selftest;
  wire dn_crit = dw.dup_addr || dw.bus_off;
  wire dn_ok = dn_go && dw.dup_done && !dn_crit && !dw.no_power;
  wire dn_flt = dw.minor_fault || dw.conn_timeout;
  wire red = led_red && !led_green;
  wire grn = led_green && !led_red;
  wire dark = !led_red && !led_green;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pers_q <= CTRL_PERS_RST;
      can_q <= CAN_RST;
      dn_q <= DN_RST;
    end else if (wr) begin
      if (paddr == CTRL_OFS) pers_q <= pwdata[CTRL_PERS_BIT];
      if (paddr == CAN_OFS) can_q <= cw;
      if (paddr == DN_OFS) dn_q <= dw;
    end
  end
  excl_a: assert property (!(led_red && led_green))
    else $error("both colours lit");
  // Write edge E, indication at E+1, LEDs at E+2, sampled from E+3
  can_dark_a: assert property (can_w && (cw.no_cfg || cw.reset_busy)
    |-> ##3 dark[*3]) else $error("can not dark");
  can_red_a: assert property (can_go && can_err |-> ##3 red)
    else $error("can no red start");
  can_grn_a: assert property (can_go && !can_err && cw.nmt != NMT_INIT
    |-> ##3 grn) else $error("can no green start");
  dn_dark_a: assert property (dn_w && !dw.selftest &&
    (!dw.dup_done || dw.no_power && !dn_crit) |-> ##3 dark[*3])
    else $error("dn not dark");
  dn_crit_a: assert property (dn_w && !dw.selftest && dw.dup_done
    && dn_crit |-> ##3 red[*3]) else $error("dn no steady red");
  dn_flash_a: assert property (dn_ok && dn_flt |-> ##3 red)
    else $error("dn no red flash start");
  dn_grn_a: assert property (dn_ok && !dn_flt
    && (dw.online || dw.cfg_bad) |-> ##3 grn) else $error("dn no green");
  dn_self_a: assert property (dn_w && dw.selftest && !dn_q.selftest
    |-> ##3 grn[*3]) else $error("self-test not green first");
endmodule
bind fmsl_top fmsl_monitor #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .led_red(led_red),
  .led_green(led_green));
`default_nettype wire

/* File: test/fmsl_led_model.sv */
// Behavioural bicolour LED
`default_nettype none
module fmsl_led_model (
  // Drive
  input wire logic led_red,
  input wire logic led_green,
  // Lit colour, bit 1 red, bit 0 green
  output logic [1:0] colour
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lit reads 2'h3, never an expected colour
  assign colour = {led_red, led_green};
endmodule
`default_nettype wire

/* File: test/fmsl_top_test.sv */
// Self-checking bench of the status LED driver
`default_nettype none
module fmsl_top_test
  import fmsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int M = 2;
  localparam int CAP = 1100 * M;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, mp;
  logic led_red, led_green;
  logic [ADDR_W-1:0] paddr, ad;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] colour;
  logic [6:0] mc;
  logic [9:0] md;
  int bad_count, comparisons, cycles, n, k, v, seed;
  int on_ms[10] = '{1100, 1100, 200, 200, 200, 200, 1100, 500, 500, 250};
  int off_ms[10] = '{1100, 0, 200, 1000, 1000, 200, 0, 500, 500, 0};
  logic [1:0] col[10] = '{0, 1, 1, 1, 2, 2, 2, 1, 2, 1};
  logic [10:0] sc[19] = '{11'h003, 11'h002, 11'h001, 11'h007, 11'h00B,
    11'h01F, 11'h023, 11'h000, 11'h600, 11'h506, 11'h504, 11'h501,
    11'h510, 11'h508, 11'h520, 11'h530, 11'h580, 11'h540, 11'h400};
  fmsl_top #(.MS_TICK_CYCLES(M)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .led_red(led_red), .led_green(led_green));
  fmsl_led_model u_led (.led_red(led_red), .led_green(led_green),
    .colour(colour));
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic int model(logic p, logic [6:0] c, logic [9:0] d);
    if (!p) begin
      if (c[6] | c[5]) return 0;
      if (c[4]) return 6;
      if (c[3]) return 5;
      if (c[2]) return 4;
      return c[1:0] == 3 ? 1 : c[1:0] == 2 ? 2 : c[1:0] == 1 ? 3 : 0;
    end
    if (d[9]) return 9;
    if (!d[8]) return 0;
    if (d[7] | d[6]) return 6;
    if (d[5]) return 0;
    if (d[4] | d[3]) return 8;
    if (d[2] & d[1]) return 1;
    return (d[2] | d[0]) ? 7 : 0;
  endfunction
  task automatic put(input logic [11:0] a, input logic [9:0] x);
    apb(1'h1, a, x);
    if (a == CTRL_OFS) mp = x[0];
    if (a == CAN_OFS) mc = x[6:0];
    if (a == DN_OFS) md = x;
  endtask
  task automatic ind_chk;
    repeat (2) @(posedge pclk);
    apb(1'h0, LED_OFS, 0);
    chk(rd[11:8], model(mp, mc, md));
  endtask
  task automatic run(input logic [1:0] c, input int on, input int off);
    for (n = 0; n < CAP && colour === c; n++) @(posedge pclk) #1;
    chk(n, on * M);
    for (n = 0; n < CAP && colour === 2'h0; n++) @(posedge pclk) #1;
    chk(n, off * M);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 70000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, mp, md} = '0;
    {paddr, pwdata} = '0;
    mc = 7'h40;
    seed = 32'h637bf576;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL_OFS, 0);
    chk(rd, 0);
    apb(1'h0, CAN_OFS, 0);
    chk(rd, 32'h40);
    apb(1'h0, DN_OFS, 0);
    chk(rd, 0);
    apb(1'h1, 12'h010, -1);
    chk(err, 1);
    apb(1'h0, 12'h010, 0);
    chk(err, 1'h1);
    chk(rd, 32'h0000_0000);
    apb(1'h1, LED_OFS, -1);
    apb(1'h0, LED_OFS, 0);
    chk(rd[11:0], 12'h000);
    apb(1'h1, CAN_OFS, -1);
    apb(1'h0, CAN_OFS, 0);
    chk(rd, 32'h7F);
    chk(err, 1'h0);
    foreach (sc[i]) begin
      ad = sc[i][10] ? DN_OFS : CAN_OFS;
      put(CTRL_OFS, 10'(sc[i][10]));
      put(ad, sc[i][10] ? 10'h000 : 10'h040);
      put(ad, sc[i][9:0]);
      repeat (2) @(posedge pclk) #1;
      k = model(mp, mc, md);
      run(col[k], on_ms[k], off_ms[k]);
      if (k == 9) run(2'h2, 250, 1100);
      ind_chk;
    end
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      put(CTRL_OFS, 10'(v[0]));
      put(CAN_OFS, 10'(v[7:1]));
      put(DN_OFS, v[17:8]);
      ind_chk;
    end
    finish_test;
  end
endmodule
`default_nettype wire
